/* rtl/trc_pkg.sv */
package trc_pkg;

    // Bus geometry
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;

    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_OPTION    = 14'h1802;
    localparam logic [13:0] IDX_TEST_STAT = 14'h180F;
    localparam logic [13:0] IDX_IRQ_STAT  = 14'h1810;
    localparam logic [13:0] IDX_IRQ_MASK  = 14'h1811;

    // Option register fields
    localparam int OPT_EN_BIT  = 3;
    localparam int OPT_THR_BIT = 2;
    // Test status register field
    localparam int TST_OOR_BIT = 0;

    // Interrupt status and mask fields
    localparam int IRQ_W           = 3;
    localparam int IRQ_SHUT_BIT    = 0;
    localparam int IRQ_RESTART_BIT = 1;
    localparam int IRQ_OOR_BIT     = 2;

    // Reset values
    localparam logic             EN_RESET   = 1'b0;
    localparam logic             THR_RESET  = 1'b0;
    localparam logic             OOR_RESET  = 1'b1;
    localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Restart reset pulse width
    localparam int CLK_PERIOD_NS    = 40;
    localparam int RESTART_PULSE_NS = 160;
    localparam int RESTART_CYCLES   =
        (RESTART_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 3;

    // Sequencer states, Gray along idle, shutdown, restart
    typedef enum logic [1:0] {
        TRC_IDLE    = 2'h0,
        TRC_SHUT    = 2'h1,
        TRC_RESTART = 2'h3
    } trc_state_e;

    // Threshold comparator outputs
    typedef struct packed {
        logic low_reached;
        logic high_reached;
        logic above_rearm;
        logic within_recovery;
    } trc_cmp_s;

endpackage

/* rtl/trc_thermal_restart_control.sv */
// Functional notes
// - Option bit 3 powers the restart unit on when set and off when clear.
// - Any controller reset clears the restart enable bit.
// - Threshold select zero picks the low threshold, one the high one.
// - Any controller reset clears threshold select, choosing low.
// - Reaching the chosen threshold while enabled enters deepest stop.
// - While shut down, periodic wakeups and periodic resets are blocked.
// - Return into the recovery range resets the controller.
// - A restart only happens if the status left the re-arm range first.
// - The out-of-range status is bit 0 of the test status register.
// - Any controller reset forces the out-of-range status to one.
// - Status one means the unit will restart on return to recovery.
// - While status is zero, writes setting the enable bit are ignored.
// - Status sets above the re-arm threshold, clears in recovery.
// - Wakeup and reset counters keep running while their outputs block.
`timescale 1ns/100ps
module trc_thermal_restart_control
    import trc_pkg::*;
#(
    parameter int RESTART_LEN = trc_pkg::RESTART_CYCLES
) (
    input  wire logic                       clock,
    input  wire logic                       reset_n,
    input  wire logic                       clk_en,
    input  wire logic [trc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [trc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [trc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [trc_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire trc_pkg::trc_cmp_s          cmp,
    input  wire logic                       pwu_wakeup_in,
    input  wire logic                       pwu_reset_in,
    output logic                            pwu_wakeup_out,
    output logic                            pwu_reset_out,
    output logic                            restart_unit_power,
    output logic                            deep_stop_out,
    output logic                            restart_reset_out,
    output logic                            irq
);
    import trc_pkg::*;

    // Register hit on a word-aligned byte address
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [13:0]       idx);
        reg_hit = (addr[ADDR_W-1:2] == idx);
    endfunction

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = reg_hit(addr, IDX_OPTION) |
                     reg_hit(addr, IDX_TEST_STAT) |
                     reg_hit(addr, IDX_IRQ_STAT) |
                     reg_hit(addr, IDX_IRQ_MASK);
    endfunction

    trc_cmp_s            cmp_meta_q;
    trc_cmp_s            cmp_sync_q;
    logic                en_q;
    logic                en_d;
    logic                thr_q;
    logic                oor_q;
    logic                oor_d;
    logic                armed_q;
    trc_state_e          state_q;
    trc_state_e          state_d;
    logic [CNT_W-1:0]    cnt_q;
    logic [IRQ_W-1:0]    stat_q;
    logic [IRQ_W-1:0]    stat_d;
    logic [IRQ_W-1:0]    mask_q;
    logic [IRQ_W-1:0]    events;
    logic                aw_hold_q;
    logic                w_hold_q;
    logic [ADDR_W-1:0]   aw_addr_q;
    logic [DATA_W-1:0]   wdata_q;
    logic [3:0]          wstrb_q;
    logic                aw_take;
    logic                w_take;
    logic                ar_take;
    logic                wr_do;
    logic                bvalid_d;
    logic                rvalid_d;
    logic                opt_wr;
    logic                mask_wr;
    logic                stat_rd;
    logic                sel_reached;
    logic                block;

    // Two-stage synchroniser on the comparator outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmp_meta_q <= '0;
            cmp_sync_q <= '0;
        end else if (clk_en) begin
            cmp_meta_q <= cmp;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Bus handshake terms
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    assign wr_do   = aw_hold_q & w_hold_q & ~s_axi_bvalid;
    assign bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
    assign rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
    assign opt_wr  = wr_do & wstrb_q[0] & reg_hit(aw_addr_q, IDX_OPTION);
    assign mask_wr = wr_do & wstrb_q[0] & reg_hit(aw_addr_q, IDX_IRQ_MASK);
    assign stat_rd = ar_take & reg_hit(s_axi_araddr, IDX_IRQ_STAT);

    // Write channel capture, address and data in either order
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_q     <= 1'b0;
            w_hold_q      <= 1'b0;
            aw_addr_q     <= '0;
            wdata_q       <= '0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else if (clk_en) begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_hold_q     <= (aw_hold_q | aw_take) & ~wr_do;
            w_hold_q      <= (w_hold_q | w_take) & ~wr_do;
            s_axi_awready <= ~((aw_hold_q | aw_take) & ~wr_do) & ~bvalid_d;
            s_axi_wready  <= ~((w_hold_q | w_take) & ~wr_do) & ~bvalid_d;
            s_axi_bvalid  <= bvalid_d;
            if (wr_do) begin
                s_axi_bresp <= reg_mapped(aw_addr_q) ? RESP_OKAY
                                                     : RESP_SLVERR;
            end
        end
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= ~rvalid_d;
            s_axi_rvalid  <= rvalid_d;
            if (ar_take) begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_OKAY;
                if (reg_hit(s_axi_araddr, IDX_OPTION)) begin
                    s_axi_rdata[OPT_EN_BIT]  <= en_q;
                    s_axi_rdata[OPT_THR_BIT] <= thr_q;
                end else if (reg_hit(s_axi_araddr, IDX_TEST_STAT)) begin
                    s_axi_rdata[TST_OOR_BIT] <= oor_q;
                end else if (reg_hit(s_axi_araddr, IDX_IRQ_STAT)) begin
                    s_axi_rdata[IRQ_W-1:0] <= stat_q;
                end else if (reg_hit(s_axi_araddr, IDX_IRQ_MASK)) begin
                    s_axi_rdata[IRQ_W-1:0] <= mask_q;
                end else begin
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
        end
    end

    // Setting the enable needs the status at one
    always_comb begin
        en_d = en_q;
        if (opt_wr) begin
            en_d = wdata_q[OPT_EN_BIT] & (oor_q | en_q);
        end
    end

    // Option register, cleared by any controller reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            en_q  <= EN_RESET;
            thr_q <= THR_RESET;
        end else if (clk_en) begin
            en_q <= en_d;
            if (opt_wr) begin
                thr_q <= wdata_q[OPT_THR_BIT];
            end
        end
    end

    // Out-of-range status with re-arm and recovery hysteresis
    always_comb begin
        oor_d = oor_q;
        if (cmp_sync_q.above_rearm) begin
            oor_d = 1'b1;
        end else if (cmp_sync_q.within_recovery) begin
            oor_d = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            oor_q <= OOR_RESET;
        end else if (clk_en) begin
            oor_q <= oor_d;
        end
    end

    // Armed once the status was out of range while enabled
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            armed_q <= 1'b0;
        end else if (clk_en) begin
            if (!en_q || state_q == TRC_RESTART) begin
                armed_q <= 1'b0;
            end else if (oor_q) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Selected threshold comparator
    assign sel_reached = thr_q ? cmp_sync_q.high_reached
                               : cmp_sync_q.low_reached;

    // Shutdown and restart sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            TRC_IDLE: begin
                if (en_q && sel_reached) begin
                    state_d = TRC_SHUT;
                end
            end
            TRC_SHUT: begin
                if (!en_q) begin
                    state_d = TRC_IDLE;
                end else if (armed_q && !oor_q) begin
                    state_d = TRC_RESTART;
                end
            end
            TRC_RESTART: begin
                if (cnt_q == '0) begin
                    state_d = TRC_IDLE;
                end
            end
            default: state_d = TRC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= TRC_IDLE;
            cnt_q   <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            if (state_q != TRC_RESTART && state_d == TRC_RESTART) begin
                cnt_q <= CNT_W'(RESTART_LEN - 1);
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Wakeup and periodic reset gate; counters outside keep running
    assign block = (state_q == TRC_SHUT) | (en_q & oor_q);

    // Registered control outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            deep_stop_out      <= 1'b0;
            restart_reset_out  <= 1'b0;
            restart_unit_power <= 1'b0;
            pwu_wakeup_out     <= 1'b0;
            pwu_reset_out      <= 1'b0;
        end else if (clk_en) begin
            deep_stop_out      <= (state_d == TRC_SHUT);
            restart_reset_out  <= (state_d == TRC_RESTART);
            restart_unit_power <= en_d;
            pwu_wakeup_out     <= pwu_wakeup_in & ~block;
            pwu_reset_out      <= pwu_reset_in & ~block;
        end
    end

    // Sticky event flags, cleared by reading; a new event wins
    always_comb begin
        events                  = '0;
        events[IRQ_SHUT_BIT]    = (state_q != TRC_SHUT) &
                                  (state_d == TRC_SHUT);
        events[IRQ_RESTART_BIT] = (state_q != TRC_RESTART) &
                                  (state_d == TRC_RESTART);
        events[IRQ_OOR_BIT]     = (oor_q != oor_d);
        stat_d = (stat_q & {IRQ_W{~stat_rd}}) | events;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stat_q <= '0;
            mask_q <= MASK_RESET;
            irq    <= 1'b0;
        end else if (clk_en) begin
            stat_q <= stat_d;
            if (mask_wr) begin
                mask_q <= wdata_q[IRQ_W-1:0];
            end
            irq <= |(stat_d & (mask_wr ? wdata_q[IRQ_W-1:0] : mask_q));
        end
    end

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_en_refused;
        clk_en && opt_wr && wdata_q[OPT_EN_BIT] && !oor_q && !en_q
        |=> !en_q && !restart_unit_power;
    endproperty
    a_en_refused: assert property (p_en_refused)
        else $error("enable set while status was zero");

    property p_shutdown;
        clk_en && state_q == TRC_IDLE && en_q && sel_reached
        |=> deep_stop_out && state_q == TRC_SHUT;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("threshold reached without deepest stop");

    property p_thr_low;
        clk_en && state_q == TRC_IDLE && en_q && !thr_q
        && !cmp_sync_q.low_reached |=> !deep_stop_out;
    endproperty
    a_thr_low: assert property (p_thr_low)
        else $error("shutdown on a threshold not selected");

    property p_pwu_block;
        clk_en && state_q == TRC_SHUT |=> !pwu_wakeup_out && !pwu_reset_out;
    endproperty
    a_pwu_block: assert property (p_pwu_block)
        else $error("wakeup or periodic reset passed during shutdown");

    property p_restart;
        clk_en && state_q == TRC_SHUT && en_q && armed_q && !oor_q
        |=> restart_reset_out && !deep_stop_out;
    endproperty
    a_restart: assert property (p_restart)
        else $error("no restart on return to recovery");

    property p_unarmed;
        state_q == TRC_SHUT && !armed_q |=> !restart_reset_out;
    endproperty
    a_unarmed: assert property (p_unarmed)
        else $error("restart without prior re-arm");

    property p_oor_set;
        clk_en && cmp_sync_q.above_rearm |=> oor_q;
    endproperty
    a_oor_set: assert property (p_oor_set)
        else $error("status not set above re-arm threshold");

    property p_oor_clr;
        clk_en && !cmp_sync_q.above_rearm && cmp_sync_q.within_recovery
        |=> !oor_q;
    endproperty
    a_oor_clr: assert property (p_oor_clr)
        else $error("status not cleared in recovery range");

    c_shutdown: cover property (clk_en && events[IRQ_SHUT_BIT]);
    c_restart:  cover property ($rose(restart_reset_out));
    c_refused:  cover property (opt_wr && wdata_q[OPT_EN_BIT] && !oor_q);

endmodule

/* verification/trc_cmp_model.sv */
`timescale 1ns/100ps
module trc_cmp_model
    import trc_pkg::*;
#(
    parameter int LOW_T   = -40,
    parameter int REARM_L = -30,
    parameter int RESET_L = -20,
    parameter int RESET_H = 100,
    parameter int REARM_H = 110,
    parameter int HIGH_T  = 125
) (
    input  wire logic               clock,
    input  wire logic signed [15:0] temp,
    input  wire logic [3:0]         lag,
    output trc_pkg::trc_cmp_s       cmp
);
    trc_cmp_s   now_v;
    logic [3:0] cnt_q;

    // Ideal comparator levels, hysteresis between the bands
    always_comb begin
        now_v.low_reached     = temp <= LOW_T;
        now_v.high_reached    = temp >= HIGH_T;
        now_v.above_rearm     = (temp >= REARM_H) || (temp <= REARM_L);
        now_v.within_recovery = (temp < RESET_H) && (temp > RESET_L);
    end

    // Analogue settling: a change shows only after lag cycles
    initial begin
        cmp   = '0;
        cnt_q = 4'h0;
    end
    always @(posedge clock) begin
        if (cmp == now_v) begin
            cnt_q <= 4'h0;
        end else if (cnt_q >= lag) begin
            cmp   <= now_v;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

/* verification/thermal_restart_control_tb.sv */
`timescale 1ns/100ps
module thermal_restart_control_tb;
    import trc_pkg::*;
    localparam int RLEN = 3;
    localparam logic [15:0] A_OPT = 16'h6008;
    localparam logic [15:0] A_TST = 16'h603C;
    localparam logic [15:0] A_IST = 16'h6040;
    localparam logic [15:0] A_MSK = 16'h6044;

    logic               clock, reset_n;
    logic [15:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic               s_axi_rready;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    trc_cmp_s           cmp;
    logic               pwu_wakeup_in, pwu_reset_in;
    logic               pwu_wakeup_out, pwu_reset_out;
    logic               restart_unit_power, deep_stop_out;
    logic               restart_reset_out, irq;
    logic signed [15:0] temp;
    logic [3:0]         lag;
    int                 mismatches, num_checks;
    logic [31:0]        rd;
    logic [1:0]         rs;
    int                 n;

    trc_thermal_restart_control #(.RESTART_LEN(RLEN)) dut (
        .clock(clock), .reset_n(reset_n), .clk_en(1'b1),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .cmp(cmp),
        .pwu_wakeup_in(pwu_wakeup_in), .pwu_reset_in(pwu_reset_in),
        .pwu_wakeup_out(pwu_wakeup_out), .pwu_reset_out(pwu_reset_out),
        .restart_unit_power(restart_unit_power),
        .deep_stop_out(deep_stop_out),
        .restart_reset_out(restart_reset_out), .irq(irq)
    );
    trc_cmp_model model (.clock(clock), .temp(temp), .lag(lag), .cmp(cmp));

    // Clock, 40 ns period
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic end_sim();
        if (mismatches == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bus write, address and data offered together
    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w  = 1'b1;
        @(posedge clock);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask

    // Bus read, compares data and response
    task automatic rdchk(input string nm, input logic [15:0] a,
                         input logic [31:0] e, input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(nm, e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask

    task automatic wait_stop(input logic v);
        n = 0;
        while (deep_stop_out !== v && n < 30) begin
            @(posedge clock);
            n++;
        end
    endtask

    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
    endtask

    // Reset values, unmapped place
    task automatic t_reset();
        rdchk("option", A_OPT, 32'h0, RESP_OKAY);
        rdchk("status", A_TST, 32'h1, RESP_OKAY);
        rdchk("mask", A_MSK, 32'h0, RESP_OKAY);
        rdchk("unmapped", 16'h6000, 32'h0, RESP_SLVERR);
        wr(16'h6004, 32'h8, RESP_SLVERR);
    endtask

    // Low shutdown, blocking, interrupt, restart
    task automatic t_low();
        wr(A_OPT, 32'h8, RESP_OKAY);
        chk("power", 1, restart_unit_power);
        temp <= -45;
        wait_stop(1'b1);
        chk("stop", 1, deep_stop_out);
        chk("irq masked", 0, irq);
        pwu_wakeup_in <= 1'b1;
        pwu_reset_in  <= 1'b1;
        repeat (2) @(posedge clock);
        chk("wakeup out", 0, pwu_wakeup_out);
        chk("reset out", 0, pwu_reset_out);
        wr(A_MSK, 32'h1, RESP_OKAY);
        @(posedge clock);
        chk("irq raised", 1, irq);
        rdchk("irq status", A_IST, 32'h1, RESP_OKAY);
        @(posedge clock);
        chk("irq cleared", 0, irq);
        temp <= 20;
        n = 0;
        while (restart_reset_out !== 1'b1 && n < 30) begin
            @(posedge clock);
            n++;
        end
        chk("restart", 1, restart_reset_out);
        n = 0;
        while (restart_reset_out === 1'b1 && n < 30) begin
            @(posedge clock);
            n++;
        end
        chk("restart len", RLEN, n);
        wait_stop(1'b0);
        chk("stop left", 0, deep_stop_out);
        rdchk("status", A_TST, 32'h0, RESP_OKAY);
        repeat (2) @(posedge clock);
        chk("wakeup out", 1, pwu_wakeup_out);
        chk("reset out", 1, pwu_reset_out);
        pwu_wakeup_in <= 1'b0;
        pwu_reset_in  <= 1'b0;
        // Second shutdown before the unit has re-armed
        temp <= -45;
        wait_stop(1'b1);
        chk("stop again", 1, deep_stop_out);
        temp <= 20;
    endtask

    // Enable refused in recovery, high threshold, slow comparators
    task automatic t_high();
        do_reset();
        repeat (8) @(posedge clock);
        rdchk("status", A_TST, 32'h0, RESP_OKAY);
        wr(A_OPT, 32'hC, RESP_OKAY);
        rdchk("option", A_OPT, 32'h4, RESP_OKAY);
        chk("power", 0, restart_unit_power);
        lag  <= 4'h5;
        temp <= 115;
        repeat (16) @(posedge clock);
        rdchk("status", A_TST, 32'h1, RESP_OKAY);
        wr(A_OPT, 32'hC, RESP_OKAY);
        rdchk("option", A_OPT, 32'hC, RESP_OKAY);
        temp <= -45;
        repeat (16) @(posedge clock);
        chk("no low stop", 0, deep_stop_out);
        temp <= 130;
        wait_stop(1'b1);
        chk("high stop", 1, deep_stop_out);
        wr(A_OPT, 32'h4, RESP_OKAY);
        wait_stop(1'b0);
        chk("stop off", 0, deep_stop_out);
        chk("power off", 0, restart_unit_power);
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        end_sim();
    end

    initial begin
        mismatches    = 0;
        num_checks    = 0;
        reset_n       = 1'b0;
        s_axi_awaddr  = 16'h0;
        s_axi_araddr  = 16'h0;
        s_axi_wdata   = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        pwu_wakeup_in = 1'b0;
        pwu_reset_in  = 1'b0;
        temp          = 115;
        lag           = 4'h0;
        do_reset();
        t_reset();
        t_low();
        t_high();
        end_sim();
    end
endmodule
